// ### swg_guard_id.sv
module swg_guard_id
  import swg_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE    = 8'h5a, // Arbitrary value.
  parameter logic [7:0] MEM_TYPE_CODE = 8'h3c, // Arbitrary value.
  parameter logic [7:0] CAPACITY_CODE = 8'h77  // Arbitrary value.
) (
  // System
  input  wire logic       clk,
  input  wire logic       resetn,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       wp_n,
  output logic            so,
  output logic            so_oe,
  // Status
  output logic [3:0]      block_protect_bits,
  output logic            protect_lock_bit,
  output logic            write_latch_bit,
  output logic            status_armed
);
  logic [1:0] cs_sync_reg, sck_sync_reg, si_sync_reg, wp_sync_reg;
  logic       cs_d_reg, sck_d_reg;
  swg_state_type state_reg;
  logic [7:0]  shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic [7:0]  out_reg;
  logic [2:0]  out_bit_reg;
  logic [1:0]  byte_idx_reg;
  logic        leg_sel_reg;
  logic        wr_pending_reg;
  logic [7:0]  wr_data_reg;
  logic        first_out_reg;

  // Pins come from the host's domain, so each passes two flip-flops.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_sync_reg  <= 2'h3;
      sck_sync_reg <= 2'h0;
      si_sync_reg  <= 2'h0;
      wp_sync_reg  <= 2'h3;
      cs_d_reg     <= 1'b1;
      sck_d_reg    <= 1'b0;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[0], cs_n};
      sck_sync_reg <= {sck_sync_reg[0], sck};
      si_sync_reg  <= {si_sync_reg[0], si};
      wp_sync_reg  <= {wp_sync_reg[0], wp_n};
      cs_d_reg     <= cs_sync_reg[1];
      sck_d_reg    <= sck_sync_reg[1];
    end
  end

  wire logic cs_low   = !cs_sync_reg[1];
  wire logic cs_rise  = cs_sync_reg[1] && !cs_d_reg;
  wire logic sck_rise = cs_low && sck_sync_reg[1] && !sck_d_reg;
  wire logic sck_fall = cs_low && !sck_sync_reg[1] && sck_d_reg;
  wire logic [7:0] in_byte = {shift_reg[6:0], si_sync_reg[1]};
  wire logic byte_done = sck_rise && (bit_cnt_reg[2:0] == 3'h7);

  function automatic logic [7:0] std_byte(input logic [1:0] idx);
    unique case (idx)
      2'h0:    std_byte = MAKER_CODE;
      2'h1:    std_byte = MEM_TYPE_CODE;
      default: std_byte = CAPACITY_CODE;
    endcase
  endfunction : std_byte

  // Command decoder; a chip-select rise ends any frame.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg   <= SWG_OPCODE;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 5'h00;
      leg_sel_reg <= 1'b0;
    end else if (!cs_low) begin
      state_reg   <= SWG_OPCODE;
      bit_cnt_reg <= 5'h00;
    end else if (sck_rise) begin
      shift_reg   <= in_byte;
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      unique case (state_reg)
        SWG_OPCODE: if (byte_done) begin
          bit_cnt_reg <= 5'h00;
          if (in_byte == OP_STATUS_WRITE)
            state_reg <= SWG_WRDATA;
          else if (in_byte == OP_STD_ID)
            state_reg <= SWG_STD_ID;
          else if (in_byte == OP_LEGACY_ID_A || in_byte == OP_LEGACY_ID_B)
            state_reg <= SWG_LEG_ADDR;
          else
            state_reg <= SWG_IGNORE;
        end
        SWG_LEG_ADDR: if (bit_cnt_reg == 5'(ADDR_BITS - 1)) begin
          leg_sel_reg <= si_sync_reg[1];
          state_reg   <= SWG_LEG_ID;
        end
        SWG_WRDATA: if (byte_done) state_reg <= SWG_IGNORE;
        default: ;
      endcase
    end
  end

  // Status write capture; it only takes effect at the ending chip-select rise.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_pending_reg <= 1'b0;
      wr_data_reg    <= 8'h00;
    end else if (cs_rise) begin
      wr_pending_reg <= 1'b0;
    end else if (sck_rise && state_reg == SWG_WRDATA && byte_done) begin
      wr_pending_reg <= 1'b1;
      wr_data_reg    <= in_byte;
    end
  end

  // Arming, write latch and the protection bits, all resolved at frame end.
  logic [7:0] last_op_reg;
  logic       op_valid_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_op_reg  <= 8'h00;
      op_valid_reg <= 1'b0;
    end else if (cs_rise) begin
      op_valid_reg <= 1'b0;
    end else if (sck_rise && state_reg == SWG_OPCODE && byte_done) begin
      last_op_reg  <= in_byte;
      op_valid_reg <= 1'b1;
    end
  end

  wire logic locked = !wp_sync_reg[1] && protect_lock_bit;
  wire logic is_status_write_cmd = op_valid_reg && last_op_reg == OP_STATUS_WRITE;
  // Either arming path counts, but a locked register swallows the whole write.
  wire logic wr_allowed = is_status_write_cmd && wr_pending_reg
                          && (status_armed || write_latch_bit) && !locked;

  // Arming lasts exactly one instruction, so any other completed opcode drops it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_armed <= 1'b0;
    end else if (cs_rise && op_valid_reg) begin
      status_armed <= (last_op_reg == OP_ARM_STATUS_WRITE);
    end
  end

  // The write latch outlives other instructions; a status write always consumes it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      write_latch_bit <= 1'b0;
    end else if (cs_rise && op_valid_reg) begin
      if (is_status_write_cmd) begin
        write_latch_bit <= 1'b0;
      end else if (last_op_reg == OP_WRITE_LATCH_SET) begin
        write_latch_bit <= 1'b1;
      end
    end
  end

  // Protection bits move only at the frame end, never from a partial data byte.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      block_protect_bits <= BP_RESET;
      protect_lock_bit   <= BPL_RESET;
    end else if (cs_rise && wr_allowed) begin
      block_protect_bits <= wr_data_reg[BP0_POS +: $bits(block_protect_bits)];
      // Pin low and lock clear: lock may only rise here.
      protect_lock_bit   <= wr_data_reg[BPL_POS];
    end
  end

  // Legacy readout begins on the addressed byte and then flips every byte.
  wire logic       out_active = cs_low && (state_reg == SWG_STD_ID || state_reg == SWG_LEG_ID);
  wire logic       leg_phase  = leg_sel_reg ^ !first_out_reg ^ byte_idx_reg[0];
  wire logic [7:0] next_byte  = (state_reg == SWG_STD_ID) ? std_byte(byte_idx_reg)
                                : (leg_phase ? CAPACITY_CODE : MAKER_CODE);

  // The enable only rises on a serial clock fall, so the pin never starts driving mid-bit.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      so_oe <= 1'b0;
    end else if (!out_active) begin
      so_oe <= 1'b0;
    end else if (sck_fall) begin
      so_oe <= 1'b1;
    end
  end

  // Output shifter: loads a byte on the first fall after the command and on every eighth fall after it, shifts on the other falls.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_reg       <= 8'h00;
      out_bit_reg   <= 3'h0;
      byte_idx_reg  <= 2'h0;
      first_out_reg <= 1'b1;
      so            <= 1'b0;
    end else if (!out_active) begin
      out_bit_reg   <= 3'h0;
      byte_idx_reg  <= 2'h0;
      first_out_reg <= 1'b1;
    end else if (sck_fall) begin
      if (out_bit_reg == 3'h0) begin
        so            <= next_byte[BYTE_BITS-1];
        out_reg       <= {next_byte[BYTE_BITS-2:0], 1'b0};
        first_out_reg <= 1'b0;
        if (state_reg == SWG_STD_ID) begin
          byte_idx_reg <= (byte_idx_reg == 2'(STD_ID_BYTES - 1)) ? 2'h0 : byte_idx_reg + 2'h1;
        end else begin
          byte_idx_reg <= {1'b0, !first_out_reg ^ byte_idx_reg[0]};
        end
      end else begin
        so      <= out_reg[BYTE_BITS-1];
        out_reg <= {out_reg[BYTE_BITS-2:0], 1'b0};
      end
      out_bit_reg <= out_bit_reg + 3'h1;
    end
  end
endmodule : swg_guard_id

// ### swg_pkg.sv
// Function
// - Status write is accepted only as the instruction right after an arming command; this design also accepts it later while the write latch is set.
// - Status write loads four block-protect bits and the protect-lock bit.
// - Status write is ignored when protect pin low and lock bit already set.
// - With protect pin low, lock bit may go 0 to 1 but never back.
// - With protect pin high, lock and all protect bits are freely writable.
// - Lock condition is judged at the chip-select rise ending the status write.
// - Opcode 9F returns an 8-bit maker code then a 16-bit device code.
// - Standard id bytes: maker code, memory type code, then capacity code.
// - A chip-select rise stops the standard id output at any point.
// - Legacy id uses opcode 90 or AB, then a 24-bit address, treated alike.
// - Legacy id returns maker code at address 0 and device code at address 1.
// - Legacy id output alternates maker and device bytes until chip select rises.
// - Write-enable also arms status write; its latch clears when status write ends.
package swg_pkg;
  localparam logic [7:0] OP_ARM_STATUS_WRITE = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE     = 8'h01;
  localparam logic [7:0] OP_WRITE_LATCH_SET  = 8'h06;
  localparam logic [7:0] OP_STD_ID           = 8'h9f;
  localparam logic [7:0] OP_LEGACY_ID_A      = 8'h90;
  localparam logic [7:0] OP_LEGACY_ID_B      = 8'hab;
  localparam int         ADDR_BITS           = 24;
  localparam int         BYTE_BITS           = 8;
  localparam int         STD_ID_BYTES        = 3;
  // Status field positions within the written data byte.
  localparam int         BP0_POS             = 2;
  localparam int         BPL_POS             = 7;
  localparam logic [3:0] BP_RESET            = 4'hf;
  localparam logic       BPL_RESET           = 1'b0;
  typedef enum logic [2:0] {
    SWG_OPCODE, SWG_WRDATA, SWG_STD_ID, SWG_LEG_ADDR, SWG_LEG_ID, SWG_IGNORE
  } swg_state_type;
endpackage : swg_pkg

// ### swg_checker.sv
module swg_checker (
  // Pins
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       wp_n,
  input wire logic       so,
  input wire logic       so_oe,
  // Status
  input wire logic [3:0] block_protect_bits,
  input wire logic       protect_lock_bit,
  input wire logic       write_latch_bit,
  input wire logic       status_armed
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  status_guard_a: assert property ($changed({block_protect_bits, protect_lock_bit}) |->
    cs_n && $past(status_armed || write_latch_bit)) else $error("status changed unguarded");
  // The pin is synchronised, so it must have been low for a while before it counts.
  lock_sticky_a: assert property (protect_lock_bit && !wp_n && !$past(wp_n, 4) |=>
    protect_lock_bit) else $error("lock bit cleared while protected");
  locked_frozen_a: assert property (protect_lock_bit && !wp_n && !$past(wp_n, 4) |=>
    $stable(block_protect_bits)) else $error("protect bits changed while locked");
  arm_on_rise_a: assert property ($rose(status_armed) |-> cs_n)
    else $error("arming before frame end");
  latch_clear_a: assert property ($fell(write_latch_bit) |-> cs_n)
    else $error("latch cleared inside frame");
  id_release_a: assert property (cs_n [*6] |-> !so_oe) else $error("output kept after deselect");
  so_fall_a: assert property (so_oe && $changed(so) |-> !sck) else $error("output moved on high clock");
  quiet_opcode_a: assert property ($fell(cs_n) |-> !so_oe [*8]) else $error("output during opcode");
  cover property ($rose(protect_lock_bit));
  cover property ($rose(so_oe));
  cover property ($fell(write_latch_bit));
endmodule : swg_checker

bind swg_guard_id swg_checker i_chk (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck),
  .wp_n(wp_n), .so(so), .so_oe(so_oe), .block_protect_bits(block_protect_bits),
  .protect_lock_bit(protect_lock_bit), .write_latch_bit(write_latch_bit),
  .status_armed(status_armed));

// ### swg_host_model.sv
module swg_host_model (
  // Link
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic     cs_n,
  output logic     sck,
  output logic     si
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Clock idles low and data moves only while it is low, so both edges stay clean.
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #40 sck = 1'b1;
      rx[i] = so_oe ? so : 1'bx;
      #40 sck = 1'b0;
    end
    si = ~si;
    #40 cs_n = 1'b1;
    #200;
  endtask : frame
endmodule : swg_host_model

// ### test_status_write_guard_and_id_readout.sv
module test_status_write_guard_and_id_readout;
  timeunit 1ns;
  timeprecision 100ps;
  import swg_pkg::*;
  localparam logic [7:0] MK = 8'h5a; // Arbitrary value.
  localparam logic [7:0] MT = 8'h3c; // Arbitrary value.
  localparam logic [7:0] CP = 8'h77; // Arbitrary value.
  logic        clk, resetn, wp_n, so, so_oe, cs_n, sck, si, lock, latch, armed;
  logic [3:0]  bp;
  logic [63:0] rx;
  int          errors, cmp_count, cyc;
  wire  [5:0]  st = {bp, lock, latch};
  swg_guard_id #(.MAKER_CODE(MK), .MEM_TYPE_CODE(MT), .CAPACITY_CODE(CP)) i_dut (.clk(clk),
    .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .block_protect_bits(bp), .protect_lock_bit(lock), .write_latch_bit(latch),
    .status_armed(armed));
  swg_host_model i_host (.clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      errors++;
  endtask : chk
  task automatic op(input logic [7:0] code);
    i_host.frame({56'h0, code}, 8, rx);
  endtask : op
  task automatic wr(input logic arm, input logic [7:0] d);
    if (arm)
      op(OP_ARM_STATUS_WRITE);
    i_host.frame({48'h0, OP_STATUS_WRITE, d}, 16, rx);
  endtask : wr
  task automatic t_guard();
    wr(1'b0, 8'h28);
    chk(24'(st), 24'h3c);
    wr(1'b1, 8'h28);
    chk(24'(st), 24'h28);
    op(OP_ARM_STATUS_WRITE);
    chk(24'(armed), 24'h1);
    op(OP_STD_ID);
    chk(24'(armed), 24'h0);
    wr(1'b0, 8'h14);
    chk(24'(st), 24'h28);
    op(OP_WRITE_LATCH_SET);
    chk(24'(st), 24'h29);
    wr(1'b0, 8'h14);
    chk(24'(st), 24'h14);
    $display("test guard done");
  endtask : t_guard
  task automatic t_lock();
    wp_n = 1'b0;
    wr(1'b1, 8'h8c);
    chk(24'(st), 24'h0e);
    wr(1'b1, 8'h00);
    chk(24'(st), 24'h0e);
    wp_n = 1'b1;
    wr(1'b1, 8'h00);
    chk(24'(st), 24'h00);
    $display("test lock done");
  endtask : t_lock
  task automatic t_ids();
    // A cut readout first, so the full one below also shows the restart at the first byte.
    i_host.frame({48'h0, OP_STD_ID, 8'h0}, 16, rx);
    chk(24'(rx[7:0]), 24'(MK));
    chk(24'(so_oe), 24'h0);
    i_host.frame({32'h0, OP_STD_ID, 24'h0}, 32, rx);
    chk(rx[23:0], {MK, MT, CP});
    // Both opcodes and both start addresses; four bytes show the start and the alternation.
    for (int k = 0; k < 4; k++) begin
      i_host.frame({k < 2 ? OP_LEGACY_ID_A : OP_LEGACY_ID_B, 23'h0, k[0], 32'h0}, 64,
                   rx);
      chk(24'(rx[31:24]), 24'(k[0] ? CP : MK));
      chk(rx[23:0], k[0] ? {MK, CP, MK} : {CP, MK, CP});
    end
    $display("test ids done");
  endtask : t_ids
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    resetn = 1'b0;
    wp_n = 1'b1;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_guard();
    t_lock();
    t_ids();
    stop_test();
  end
endmodule : test_status_write_guard_and_id_readout
